/* src/plld_map.svh */
// Purpose: register map, reset values, field positions and timing of the lock detector
// Assumes: 100 MHz block clock
// Notes:   definitions only
`ifndef PLLD_MAP_SVH
`define PLLD_MAP_SVH

`define PLLD_ADDR_LD      6'h07
`define PLLD_ADDR_AEN     6'h08
`define PLLD_LD_RST       24'h00014D
`define PLLD_AEN_RST      24'hC1BEFF
`define PLLD_LD_MASK      24'h003FFF
`define PLLD_AEN_RSV      3'h3

`define PLLD_LD_CNTSEL    2:0
`define PLLD_LD_EN        3
`define PLLD_LD_WINTYPE   6
`define PLLD_LD_WINDUR    9:7
`define PLLD_LD_TFREQ     11:10
`define PLLD_LD_TTEST     12
`define PLLD_LD_RELOCK    13
`define PLLD_AEN_PAD      5
`define PLLD_AEN_RSV_A    14:12
`define PLLD_AEN_RSV_B    17:15
`define PLLD_AEN_LOW      11:0
`define PLLD_AEN_HIGH     23:18

`define PLLD_CNT_0        16'h0005
`define PLLD_CNT_1        16'h0020
`define PLLD_CNT_2        16'h0060
`define PLLD_CNT_3        16'h0100
`define PLLD_CNT_4        16'h0200
`define PLLD_CNT_5        16'h0800
`define PLLD_CNT_6        16'h2000
`define PLLD_CNT_7        16'hFFFF

`define PLLD_CLK_MHZ      100
`define PLLD_ANA_WIN_NS   10
`define PLLD_ANA_WIN_CYC  (((`PLLD_ANA_WIN_NS * `PLLD_CLK_MHZ) / 1000) < 1 ? 1 : \
                           ((`PLLD_ANA_WIN_NS * `PLLD_CLK_MHZ) / 1000))

`endif

/* src/plld_pkg.sv */
// Purpose: shared types of the lock detector
// Assumes: nothing
// Notes:   states of the detection window
`default_nettype none
package plld_pkg;
    typedef enum logic [0:0] {
        PLLD_WIN_IDLE = 1'b0,
        PLLD_WIN_OPEN = 1'b1
    } plld_win_type;
endpackage
`default_nettype wire

/* src/plld_lock_detect.sv */
// Purpose: lock detector with its configuration and analog-enable registers
// Assumes: ref and divided edges are one-cycle pulses from on-chip dividers on clk_in
// Notes:   analog window is an internal one-shot model of fixed length
//
// Summary of operation
// - lock is declared after the selected number (5,32,96,256,512,2048,8192,65535) of hits.
// - detection runs only while the lock-detect enable bit is set, reset one.
// - the window-type bit picks the digital timer (1) or the 10 ns analog one-shot (0).
// - the duration field gives 1/2,1,2,4,8,16,32,64 timer cycles, reset code 2.
// - a 2-bit field sets the timer rate, 00 fastest and 11 slowest, reset 00.
// - the test bit keeps the timer clock running, otherwise it is one-shot per measurement.
// - with auto-relock set a lost lock starts one relock attempt and no retry.
// - with the pad enable bit clear the lock/serial-out pin driver is off.
// - with pad enable and serial-mode bit 7 set the pin always drives.
// - the lock-detect configuration resets to 00014Dh.
// - the analog-enable register resets to C1BEFFh with reserved fields held at 011.
`include "plld_map.svh"
`default_nettype none
module plld_lock_detect
    import plld_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // register port from the serial interface
    input  wire logic        reg_wr_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [23:0] reg_wdata_in,
    output logic      [23:0] reg_rdata_out,
    // serial interface state
    input  wire logic        serial_mode_gpo_in,
    input  wire logic        serial_active_in,
    input  wire logic        serial_addr_match_in,
    input  wire logic        serial_data_in,
    // divider edges
    input  wire logic        ref_edge_in,
    input  wire logic        div_edge_in,
    // status and control outputs
    output logic             lock_detect_out,
    output logic             relock_start_out,
    output logic      [23:0] analog_enable_out,
    // lock/serial-out pin
    output logic             lock_serial_out_pin_out,
    output logic             lock_serial_out_pin_oe_n_out
);
    logic [23:0]  ld_cfg_q;
    logic [23:0]  aen_cfg_q;
    plld_win_type win_state_q;
    logic [7:0]   win_cnt_q;
    logic [5:0]   div_q;
    logic [15:0]  hit_cnt_q;
    logic         lock_q;
    logic         relock_used_q;
    logic         tick_en;
    logic         hit;
    logic         miss;
    logic         ld_en;
    logic [15:0]  target;

    function automatic logic [15:0] lock_target(input logic [2:0] sel);
        case (sel)
            3'h0:    lock_target = `PLLD_CNT_0;
            3'h1:    lock_target = `PLLD_CNT_1;
            3'h2:    lock_target = `PLLD_CNT_2;
            3'h3:    lock_target = `PLLD_CNT_3;
            3'h4:    lock_target = `PLLD_CNT_4;
            3'h5:    lock_target = `PLLD_CNT_5;
            3'h6:    lock_target = `PLLD_CNT_6;
            default: lock_target = `PLLD_CNT_7;
        endcase
    endfunction

    // window length in half timer cycles
    function automatic logic [7:0] win_len(input logic [2:0] code);
        win_len = (code == 3'h0) ? 8'h01 : (8'h01 << code);
    endfunction

    // last count of a half timer cycle: 0, 3, 15 or 63, for 1, 4, 16 or 64 clocks
    function automatic logic [5:0] tick_last(input logic [1:0] f);
        tick_last = 6'((7'h01 << {f, 1'b0}) - 7'h01);
    endfunction

    assign ld_en  = ld_cfg_q[`PLLD_LD_EN];
    assign target = lock_target(ld_cfg_q[`PLLD_LD_CNTSEL]);
    assign tick_en = (div_q == tick_last(ld_cfg_q[`PLLD_LD_TFREQ]));
    // a divided edge coinciding with the reference edge counts as inside the window
    assign hit  = ld_en && div_edge_in && (win_state_q == PLLD_WIN_OPEN || ref_edge_in);
    assign miss = ld_en && div_edge_in && !hit;

    // registers; reserved analog fields are not writable so they cannot leave 011
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ld_cfg_q  <= `PLLD_LD_RST;
            aen_cfg_q <= `PLLD_AEN_RST;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `PLLD_ADDR_LD) begin
                ld_cfg_q <= reg_wdata_in & `PLLD_LD_MASK;
            end
            if (reg_addr_in == `PLLD_ADDR_AEN) begin
                aen_cfg_q <= {reg_wdata_in[`PLLD_AEN_HIGH], `PLLD_AEN_RSV, `PLLD_AEN_RSV,
                              reg_wdata_in[`PLLD_AEN_LOW]};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 24'h000000;
        end else begin
            case (reg_addr_in)
                `PLLD_ADDR_LD:  reg_rdata_out <= ld_cfg_q;
                `PLLD_ADDR_AEN: reg_rdata_out <= aen_cfg_q;
                default:        reg_rdata_out <= 24'h000000;
            endcase
        end
    end

    // timer prescaler; in one-shot mode it is held at zero between measurements
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            div_q <= 6'h00;
        end else if (ref_edge_in && !ld_cfg_q[`PLLD_LD_TTEST]) begin
            div_q <= 6'h00;
        end else if (ld_cfg_q[`PLLD_LD_TTEST] || win_state_q == PLLD_WIN_OPEN) begin
            div_q <= tick_en ? 6'h00 : div_q + 6'h01;
        end else begin
            div_q <= 6'h00;
        end
    end

    // detection window opened by each reference edge
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            win_state_q <= PLLD_WIN_IDLE;
            win_cnt_q   <= 8'h00;
        end else if (!ld_en) begin
            win_state_q <= PLLD_WIN_IDLE;
            win_cnt_q   <= 8'h00;
        end else if (ref_edge_in) begin
            win_state_q <= PLLD_WIN_OPEN;
            if (ld_cfg_q[`PLLD_LD_WINTYPE]) begin
                win_cnt_q <= win_len(ld_cfg_q[`PLLD_LD_WINDUR]);
            end else begin
                win_cnt_q <= 8'(`PLLD_ANA_WIN_CYC);
            end
        end else begin
            case (win_state_q)
                PLLD_WIN_OPEN: begin
                    // analog window counts clocks, digital counts half timer cycles
                    if (!ld_cfg_q[`PLLD_LD_WINTYPE] || tick_en) begin
                        win_cnt_q <= win_cnt_q - 8'h01;
                        if (win_cnt_q == 8'h01) begin
                            win_state_q <= PLLD_WIN_IDLE;
                        end
                    end
                end
                default: begin
                    win_state_q <= PLLD_WIN_IDLE;
                    win_cnt_q   <= 8'h00;
                end
            endcase
        end
    end

    // consecutive hit counter and lock flag
    always_ff @(posedge clk_in) begin
        if (!resetn_in || !ld_en) begin
            hit_cnt_q <= 16'h0000;
            lock_q    <= 1'b0;
        end else if (miss) begin
            hit_cnt_q <= 16'h0000;
            lock_q    <= 1'b0;
        end else if (hit && !lock_q) begin
            hit_cnt_q <= hit_cnt_q + 16'h0001;
            if (hit_cnt_q + 16'h0001 >= target) begin
                lock_q <= 1'b1;
            end
        end
    end

    // single relock try; rearmed only by rewriting the lock-detect configuration
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            relock_used_q    <= 1'b0;
            relock_start_out <= 1'b0;
        end else begin
            relock_start_out <= 1'b0;
            if (ld_cfg_q[`PLLD_LD_RELOCK] && !relock_used_q && lock_q && (miss || !ld_en)) begin
                relock_start_out <= 1'b1;
                relock_used_q    <= 1'b1;
            end else if (reg_wr_in && reg_addr_in == `PLLD_ADDR_LD) begin
                relock_used_q <= 1'b0;
            end
        end
    end

    // pad control; serial readback has priority over the lock level
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            lock_serial_out_pin_out      <= 1'b0;
            lock_serial_out_pin_oe_n_out <= 1'b1;
        end else begin
            lock_serial_out_pin_out <= serial_active_in ? serial_data_in : lock_q;
            if (!aen_cfg_q[`PLLD_AEN_PAD]) begin
                lock_serial_out_pin_oe_n_out <= 1'b1;
            end else if (serial_mode_gpo_in) begin
                lock_serial_out_pin_oe_n_out <= 1'b0;
            end else begin
                lock_serial_out_pin_oe_n_out <= serial_active_in && !serial_addr_match_in;
            end
        end
    end

    assign lock_detect_out   = lock_q;
    assign analog_enable_out = aen_cfg_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_lock_after_hit: assert property ($rose(lock_q) |-> $past(hit))
        else $error("lock rose without a hit");
    a_lock_count: assert property ($rose(lock_q)
        |-> $past(hit_cnt_q) + 16'h0001 >= $past(target))
        else $error("lock rose before the hit target");
    a_miss_clears: assert property (miss |=> !lock_q && hit_cnt_q == 16'h0000)
        else $error("miss did not clear lock");
    a_disable_idle: assert property (!ld_en |=> !lock_q && win_state_q == PLLD_WIN_IDLE)
        else $error("detector active while disabled");
    a_analog_len: assert property (ref_edge_in && ld_en && !ld_cfg_q[`PLLD_LD_WINTYPE]
        |=> win_cnt_q == 8'(`PLLD_ANA_WIN_CYC))
        else $error("analog window length wrong");
    a_digital_len: assert property (ref_edge_in && ld_en && ld_cfg_q[`PLLD_LD_WINTYPE]
        |=> win_cnt_q == win_len($past(ld_cfg_q[`PLLD_LD_WINDUR])))
        else $error("digital window length wrong");
    // a rate change written on the tick edge may legally tick again at once
    a_tick_spacing: assert property (tick_en && ld_cfg_q[`PLLD_LD_TFREQ] != 2'h0
        && $stable(ld_cfg_q) && !(reg_wr_in && reg_addr_in == `PLLD_ADDR_LD) |=> !tick_en)
        else $error("slow timer ticked twice in a row");
    a_test_free: assert property (ld_cfg_q[`PLLD_LD_TTEST] && !tick_en
        |=> div_q == $past(div_q) + 6'h01)
        else $error("test timer did not run");
    a_relock_once: assert property (relock_start_out
        |-> relock_used_q ##1 !relock_start_out)
        else $error("relock retried");
    a_pad_off: assert property (!aen_cfg_q[`PLLD_AEN_PAD] |=> lock_serial_out_pin_oe_n_out)
        else $error("pad driven while disabled");
    a_gpo_drive: assert property (aen_cfg_q[`PLLD_AEN_PAD] && serial_mode_gpo_in
        |=> !lock_serial_out_pin_oe_n_out)
        else $error("pad off in gpo mode");
    a_shared_off: assert property (aen_cfg_q[`PLLD_AEN_PAD] && !serial_mode_gpo_in
        && serial_active_in && !serial_addr_match_in |=> lock_serial_out_pin_oe_n_out)
        else $error("pad driving on foreign address");
    a_reset_vals: assert property (@(posedge clk_in) disable iff (1'b0) !resetn_in
        |=> ld_cfg_q == `PLLD_LD_RST && aen_cfg_q == `PLLD_AEN_RST)
        else $error("reset values wrong");

    c_lock_reached: cover property ($rose(lock_q));
    c_relock_fired: cover property (relock_start_out);
    c_shared_off:   cover property (serial_active_in && lock_serial_out_pin_oe_n_out);
endmodule
`default_nettype wire

/* tb/plld_host_model.sv */
// Purpose: serial programming host model driving the register port
// Assumes: one write or read per call, launched at the falling edge
// Notes:   enable bits 4:0 are always kept set on analog-enable writes
`default_nettype none
module plld_host_model #(
    parameter int REF_MHZ = 50
) (
    input  wire logic        clk_in,
    input  wire logic [23:0] reg_rdata_in,
    output logic             reg_wr_out,
    output logic      [5:0]  reg_addr_out,
    output logic      [23:0] reg_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_out    = 1'b0;
        reg_addr_out  = 6'h00;
        reg_wdata_out = 24'h000000;
    end
    task automatic wr_reg(input logic [5:0] addr, input logic [23:0] data);
        logic [23:0] word;
        word = data;
        if (addr == 6'h08) begin
            word[4:0] = 5'h1F;
            word[21]  = (REF_MHZ >= 200);
        end
        @(negedge clk_in);
        reg_wr_out    = 1'b1;
        reg_addr_out  = addr;
        reg_wdata_out = word;
        @(negedge clk_in);
        reg_wr_out    = 1'b0;
        // stale data would hide a strobe-qualification slip
        reg_wdata_out = ~word;
    endtask
    task automatic rd_reg(input logic [5:0] addr, output logic [23:0] data);
        @(negedge clk_in);
        reg_addr_out = addr;
        @(negedge clk_in);
        data = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench of the lock detector
// Assumes: 100 MHz clock, divider edges as one-cycle pulses
// Notes:   counts 8192 and 65535 are left out to keep the run short
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, resetn_in, gpo, act, match, sdata, ref_e, div_e, wr;
    logic lock, relock, pin, oe_n;
    logic [5:0] addr;
    logic [23:0] wdata, rdata, aen, rd;
    int miscompares = 0;
    int n_checks = 0;
    int relocks = 0;
    int n0;
    int tgt[6] = '{5, 32, 96, 256, 512, 2048};
    plld_lock_detect dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(wr),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .serial_mode_gpo_in(gpo), .serial_active_in(act), .serial_addr_match_in(match),
        .serial_data_in(sdata), .ref_edge_in(ref_e), .div_edge_in(div_e),
        .lock_detect_out(lock), .relock_start_out(relock), .analog_enable_out(aen),
        .lock_serial_out_pin_out(pin), .lock_serial_out_pin_oe_n_out(oe_n));
    plld_host_model host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_wr_out(wr),
        .reg_addr_out(addr), .reg_wdata_out(wdata));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (resetn_in === 1'b1 && relock === 1'b1) begin
            relocks++;
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // gap 0 puts both edges in one cycle; a long gap lands outside the window
    task automatic pair(input int gap, input int n);
        repeat (n) begin
            @(negedge clk_in);
            ref_e = 1'b1;
            div_e = (gap == 0);
            @(negedge clk_in);
            ref_e = 1'b0;
            div_e = 1'b0;
            if (gap > 0) begin
                repeat (gap - 1) @(negedge clk_in);
                div_e = 1'b1;
                @(negedge clk_in);
                div_e = 1'b0;
            end
            repeat (2) @(negedge clk_in);
        end
    endtask
    task automatic pin_case(input logic g, a, m, d, input logic [1:0] exp);
        @(negedge clk_in);
        {gpo, act, match, sdata} = {g, a, m, d};
        repeat (2) @(negedge clk_in);
        chk({22'h0, oe_n, pin}, {22'h0, exp});
    endtask
    initial begin
        {resetn_in, gpo, act, match, sdata, ref_e, div_e} = 7'h00;
        repeat (6) @(negedge clk_in);
        resetn_in = 1'b1;
        chk(aen, 24'hC1BEFF);
        host.rd_reg(6'h07, rd);
        chk(rd, 24'h00014D);
        host.rd_reg(6'h08, rd);
        chk(rd, 24'hC1BEFF);
        host.rd_reg(6'h3F, rd);
        chk(rd, 24'h000000);
        pin_case(1'b1, 1'b1, 1'b0, 1'b1, 2'b01);
        pin_case(1'b0, 1'b1, 1'b0, 1'b1, 2'b11);
        pin_case(1'b0, 1'b1, 1'b1, 1'b1, 2'b01);
        host.wr_reg(6'h08, 24'h000000);
        host.rd_reg(6'h08, rd);
        chk(rd, 24'h01B01F);
        pin_case(1'b1, 1'b0, 1'b0, 1'b0, 2'b10);
        host.wr_reg(6'h08, 24'hC1BEFF);
        pin_case(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
        host.wr_reg(6'h07, 24'hFFFFFF);
        host.rd_reg(6'h07, rd);
        chk(rd, 24'h003FFF);
        for (int c = 0; c < 6; c++) begin
            host.wr_reg(6'h07, 24'h000008 | 24'(c));
            pair(0, tgt[c] - 1);
            chk({23'h0, lock}, 24'h0);
            pair(0, 1);
            chk({23'h0, lock}, 24'h1);
            chk({23'h0, pin}, 24'h1);
            pair(20, 1);
            chk({23'h0, lock}, 24'h0);
        end
        // back to the five-hit target so one miss between short runs is visible
        host.wr_reg(6'h07, 24'h000008);
        pair(0, 4);
        pair(20, 1);
        pair(0, 4);
        chk({23'h0, lock}, 24'h0);
        pair(0, 1);
        chk({23'h0, lock}, 24'h1);
        host.wr_reg(6'h07, 24'h000000);
        repeat (2) @(negedge clk_in);
        chk({23'h0, lock}, 24'h0);
        pair(0, 6);
        chk({23'h0, lock}, 24'h0);
        host.wr_reg(6'h07, 24'h000008);
        pair(2, 6);
        chk({23'h0, lock}, 24'h0);
        host.wr_reg(6'h07, 24'h000D48);
        pair(20, 5);
        chk({23'h0, lock}, 24'h1);
        host.wr_reg(6'h07, 24'h000148);
        pair(20, 1);
        chk({23'h0, lock}, 24'h0);
        n0 = relocks;
        host.wr_reg(6'h07, 24'h002008);
        pair(0, 5);
        pair(20, 1);
        chk(24'(relocks - n0), 24'h1);
        pair(0, 5);
        pair(20, 1);
        chk(24'(relocks - n0), 24'h1);
        // slowest rate, half-cycle window: one-shot timing restarts at every ref edge
        host.wr_reg(6'h07, 24'h000C48);
        pair(60, 5);
        chk({23'h0, lock}, 24'h1);
        pair(70, 1);
        chk({23'h0, lock}, 24'h0);
        end_of_test();
    end
    initial begin
        #500_000;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
